//--- inc/crt_pkg.sv
// Shared constants, register map and instruction decoding for the register transfer port
package crt_pkg;

  // Widths
  localparam int DW     = 32;
  localparam int ADDR_W = 8;
  localparam int IRQ_W  = 3;
  localparam int BANK_N = 8;
  localparam int CNT_W  = 8;

  // Instruction field positions
  localparam int COND_LSB = 28;
  localparam int L_BIT    = 20;
  localparam int PRIMARY_LSB = 16;
  localparam int RD_LSB   = 12;
  localparam int NUM_LSB  = 8;
  localparam int FLAG_LSB = 28;

  // Special register and coprocessor numbers
  localparam logic [3:0]    PC_REG         = 4'hF;
  localparam logic [3:0]    CP_CTRL_NUM    = 4'hF;
  localparam logic [3:0]    CTRL_FIRST_BAD = 4'h8;
  localparam logic [DW-1:0] PC_AHEAD       = 32'h0000000C;

  // Register byte offsets on the bus
  localparam logic [ADDR_W-1:0] OFF_INSTR    = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_OPERAND  = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_PC       = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_MODE     = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_FLAGS    = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_RESULT   = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_STATUS   = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_INT_STAT = 8'h1C;
  localparam logic [ADDR_W-1:0] OFF_INT_MASK = 8'h20;

  // Interrupt status bit positions
  localparam int IRQ_DONE = 0;
  localparam int IRQ_TRAP = 1;
  localparam int IRQ_SKIP = 2;

  // Outcome of the last instruction
  localparam logic [1:0] OUT_NONE = 2'h0;
  localparam logic [1:0] OUT_DONE = 2'h1;
  localparam logic [1:0] OUT_TRAP = 2'h2;
  localparam logic [1:0] OUT_SKIP = 2'h3;

  // Reset values
  localparam logic [DW-1:0] CTRL_ID_RST = 32'h00C0FFEE;  // Identity value is arbitrary
  localparam logic [3:0]    FLAGS_RST   = 4'h0;

  // Condition field against N Z C V flags
  function automatic logic crt_cond_pass(input logic [3:0] c, input logic [3:0] f);
    logic r;
    unique case (c[3:1])
      3'h0: r = f[2];
      3'h1: r = f[1];
      3'h2: r = f[3];
      3'h3: r = f[0];
      3'h4: r = f[1] & ~f[2];
      3'h5: r = (f[3] == f[0]);
      3'h6: r = ~f[2] & (f[3] == f[0]);
      default: r = 1'b1;
    endcase
    return c[0] ? ~r : r;
  endfunction

  // Register transfer encoding
  function automatic logic crt_is_reg_xfer(input logic [DW-1:0] i);
    return (i[27:24] == 4'hE) && i[4];
  endfunction

  // Undefined instruction encoding
  function automatic logic crt_is_undef(input logic [DW-1:0] i);
    return (i[27:25] == 3'h3) && i[4];
  endfunction

endpackage

//--- inc/crt_if.sv
// Coprocessor handshake carrier between processor end and coprocessor end
`timescale 1ns/10ps
`default_nettype none
interface crt_if;
  logic        offer;
  logic [31:0] instr;
  logic [31:0] core_data;
  logic        absent;
  logic        busy;
  logic [31:0] cp_data;

  modport core  (output offer, instr, core_data, input absent, busy, cp_data);
  modport copro (input offer, instr, core_data, output absent, busy, cp_data);
endinterface
`default_nettype wire

//--- verilog/crt_ctl_bank.sv
// Internal control coprocessor register bank, eight words
`timescale 1ns/10ps
`default_nettype none
module crt_ctl_bank (
  input  wire logic                  mclk,
  input  wire logic                  sys_rst,
  input  wire logic                  wr_en,
  input  wire logic [2:0]            idx,
  input  wire logic [crt_pkg::DW-1:0] wdata,
  output logic      [crt_pkg::DW-1:0] rdata
);
  import crt_pkg::*;

  typedef struct packed {
    logic [BANK_N-1:0][DW-1:0] word;
  } crt_bank_s;

  crt_bank_s s;
  crt_bank_s next_s;

  // Word 0 is the identity and never takes a write
  always_comb begin
    next_s = s;
    if (wr_en && (idx != 3'h0)) begin
      next_s.word[idx] = wdata;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      s         <= '0;
      s.word[0] <= CTRL_ID_RST;
    end else begin
      s <= next_s;
    end
  end

  // Read is immediate so a transfer finishes in one cycle
  assign rdata = s.word[idx];
endmodule
`default_nettype wire

//--- verilog/crt_copro_end.sv
// External coprocessor end: answers register transfers for its own number
`timescale 1ns/10ps
`default_nettype none
module crt_copro_end #(
  parameter int unsigned CP_NUM      = 1,
  parameter int unsigned BUSY_CYCLES = 2
) (
  input  wire logic                   mclk,
  input  wire logic                   sys_rst,
  crt_if.copro                        cp,
  input  wire logic [3:0]             peek_sel,
  output logic      [crt_pkg::DW-1:0] peek_data,
  output logic                        xfer_pulse,
  output logic                        xfer_dir
);
  import crt_pkg::*;

  typedef struct packed {
    logic [15:0][DW-1:0] regs;
    logic [CNT_W-1:0]    cnt;
    logic                seen;
    logic [DW-1:0]       data;
    logic [DW-1:0]       peek;
    logic                xfer;
    logic                dir;
  } crt_copro_s;

  crt_copro_s s;
  crt_copro_s next_s;
  logic       mine;
  logic       accept;
  logic [3:0] coproc_primary_register;

  // Respond only to a transfer carrying our number
  assign coproc_primary_register = cp.instr[PRIMARY_LSB +: 4];
  assign mine   = cp.offer && crt_is_reg_xfer(cp.instr)
                  && (cp.instr[NUM_LSB +: 4] == CP_NUM[3:0]);
  assign accept = mine && s.seen && (s.cnt == '0);

  // Anything not ours, undefined included, is declined with both lines high
  assign cp.absent = cp.offer && !mine;
  assign cp.busy   = cp.offer && (!mine || !s.seen || (s.cnt != '0));
  assign cp.cp_data = s.data;

  // Busy count, data staging and register write on acceptance
  always_comb begin
    next_s      = s;
    next_s.seen = mine;
    next_s.xfer = accept;
    next_s.peek = s.regs[peek_sel];
    if (mine && !s.seen) begin
      next_s.cnt = CNT_W'(BUSY_CYCLES);
    end else if (s.cnt != '0) begin
      next_s.cnt = s.cnt - 1'b1;
    end
    // Primary register is the source or destination, opcode fields unused here
    if (mine) begin
      next_s.data = s.regs[coproc_primary_register];
    end
    if (accept) begin
      next_s.dir = cp.instr[L_BIT];
      if (!cp.instr[L_BIT]) begin
        next_s.regs[coproc_primary_register] = cp.core_data;
      end
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign peek_data  = s.peek;
  assign xfer_pulse = s.xfer;
  assign xfer_dir   = s.dir;
endmodule
`default_nettype wire

//--- verilog/crt_core_end.sv
// Processor end: executes register transfer and undefined instructions under software control
`timescale 1ns/10ps
`default_nettype none
// How it works
// - Condition false means instruction does nothing.
// - Data operations take the undefined trap.
// - Load bit picks direction of the move.
// - Into PC: word bits 31..28 set NZCV.
// - Into PC: other bits and PC untouched.
// - Out of PC: send instruction address plus 12.
// - Number 15 goes to internal control bank.
// - Number field selects the answering coprocessor.
// - Opcode and register fields belong to coprocessor.
// - True undefined instruction takes the trap.
// - Coprocessors decline undefined with absent and busy.
// - Each transfer moves exactly one 32-bit word.
// - Control bank access in user mode traps.
// - Control bank registers 8 to 15 trap.
module crt_core_end (
  input  wire logic                   mclk,
  input  wire logic                   sys_rst,
  crt_if.core                         cp,
  input  wire logic                   hsel,
  input  wire logic [31:0]            haddr,
  input  wire logic [1:0]             htrans,
  input  wire logic                   hwrite,
  input  wire logic [2:0]             hsize,
  input  wire logic [crt_pkg::DW-1:0] hwdata,
  input  wire logic                   hready,
  output logic                        hreadyout,
  output logic                        hresp,
  output logic      [crt_pkg::DW-1:0] hrdata,
  output logic                        irq
);
  import crt_pkg::*;

  typedef enum logic [1:0] {ST_IDLE, ST_OFFER, ST_UNDEF} crt_core_state_e;

  typedef struct packed {
    crt_core_state_e   st;
    logic              go;
    logic [DW-1:0]     instr;
    logic [DW-1:0]     operand;
    logic [DW-1:0]     pc;
    logic [DW-1:0]     result;
    logic [DW-1:0]     core_data;
    logic [DW-1:0]     rdata;
    logic              priv;
    logic [3:0]        flags;
    logic [1:0]        outcome;
    logic [IRQ_W-1:0]  stat;
    logic [IRQ_W-1:0]  mask;
    logic              offer;
    logic              a_valid;
    logic              a_write;
    logic [ADDR_W-1:0] a_addr;
  } crt_core_s;

  crt_core_s        s;
  crt_core_s        next_s;
  logic [IRQ_W-1:0] irq_set;
  logic [IRQ_W-1:0] irq_clr;
  logic             bank_we;
  logic [DW-1:0]    bank_rdata;
  logic [DW-1:0]    xfer_word;
  logic [3:0]       cpnum;
  logic [3:0]       coproc_primary_register;
  logic [3:0]       rd;
  logic             lbit;
  logic             busy_now;

  // Instruction fields of the held instruction
  assign cpnum    = s.instr[NUM_LSB +: 4];
  assign coproc_primary_register = s.instr[PRIMARY_LSB +: 4];
  assign rd       = s.instr[RD_LSB +: 4];
  assign lbit     = s.instr[L_BIT];
  assign busy_now = (s.st != ST_IDLE) || s.go;

  // Word sent out of the core: PC reads ahead by three instructions
  assign xfer_word = (rd == PC_REG) ? (s.pc + PC_AHEAD) : s.operand;

  crt_ctl_bank u_bank (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .wr_en   (bank_we),
    .idx     (coproc_primary_register[2:0]),
    .wdata   (xfer_word),
    .rdata   (bank_rdata)
  );

  // Bus slave, decode, execution and interrupt status in one next-state process
  always_comb begin
    next_s  = s;
    irq_set = '0;
    irq_clr = '0;
    bank_we = 1'b0;

    // Data phase write; the instruction register starts work only when idle
    if (s.a_valid && s.a_write) begin
      unique case (s.a_addr)
        OFF_INSTR: begin
          if (!busy_now) begin
            next_s.instr = hwdata;
            next_s.go    = 1'b1;
          end
        end
        OFF_OPERAND:  next_s.operand = hwdata;
        OFF_PC:       next_s.pc      = hwdata;
        OFF_MODE:     next_s.priv    = hwdata[0];
        OFF_FLAGS:    next_s.flags   = hwdata[3:0];
        OFF_INT_STAT: irq_clr        = hwdata[IRQ_W-1:0];
        OFF_INT_MASK: next_s.mask    = hwdata[IRQ_W-1:0];
        default: ;
      endcase
    end

    // Execution; it follows the bus writes so hardware flag updates win
    unique case (s.st)
      ST_IDLE: begin
        if (s.go) begin
          next_s.go = 1'b0;
          if (!crt_cond_pass(s.instr[COND_LSB +: 4], s.flags)) begin
            next_s.outcome     = OUT_SKIP;
            irq_set[IRQ_SKIP] = 1'b1;
          end else if (crt_is_reg_xfer(s.instr) && (cpnum == CP_CTRL_NUM)) begin
            // Control bank is served locally and never offered outside
            if (!s.priv || (coproc_primary_register >= CTRL_FIRST_BAD)) begin
              next_s.outcome     = OUT_TRAP;
              irq_set[IRQ_TRAP] = 1'b1;
            end else begin
              if (!lbit) begin
                bank_we = 1'b1;
              end else if (rd == PC_REG) begin
                next_s.flags = bank_rdata[FLAG_LSB +: 4];
              end else begin
                next_s.result = bank_rdata;
              end
              next_s.outcome     = OUT_DONE;
              irq_set[IRQ_DONE] = 1'b1;
            end
          end else if (crt_is_reg_xfer(s.instr)) begin
            // Operand is latched once so it stays stable through the offer
            next_s.core_data = xfer_word;
            next_s.offer     = 1'b1;
            next_s.st        = ST_OFFER;
          end else if (crt_is_undef(s.instr)) begin
            next_s.offer = 1'b1;
            next_s.st    = ST_UNDEF;
          end else begin
            // Data operations and all other encodings are left to emulation
            next_s.outcome     = OUT_TRAP;
            irq_set[IRQ_TRAP] = 1'b1;
          end
        end
      end
      ST_OFFER: begin
        // No upper bound on busy: a stuck coprocessor stalls the port
        if (cp.absent) begin
          next_s.offer       = 1'b0;
          next_s.st          = ST_IDLE;
          next_s.outcome     = OUT_TRAP;
          irq_set[IRQ_TRAP] = 1'b1;
        end else if (!cp.busy) begin
          next_s.offer = 1'b0;
          next_s.st    = ST_IDLE;
          if (lbit) begin
            if (rd == PC_REG) begin
              next_s.flags = cp.cp_data[FLAG_LSB +: 4];
            end else begin
              next_s.result = cp.cp_data;
            end
          end
          next_s.outcome     = OUT_DONE;
          irq_set[IRQ_DONE] = 1'b1;
        end
      end
      ST_UNDEF: begin
        // One offer cycle lets coprocessors refuse, the trap follows regardless
        next_s.offer       = 1'b0;
        next_s.st          = ST_IDLE;
        next_s.outcome     = OUT_TRAP;
        irq_set[IRQ_TRAP] = 1'b1;
      end
    endcase

    // Sticky status: a new event beats a same-cycle clear
    next_s.stat = (s.stat & ~irq_clr) | irq_set;

    // Address phase capture; read data is ready for the following data phase
    next_s.a_valid = hsel && hready && htrans[1];
    if (hsel && hready && htrans[1]) begin
      next_s.a_write = hwrite;
      next_s.a_addr  = haddr[ADDR_W-1:0];
      unique case (haddr[ADDR_W-1:0])
        OFF_INSTR:    next_s.rdata = s.instr;
        OFF_OPERAND:  next_s.rdata = s.operand;
        OFF_PC:       next_s.rdata = s.pc;
        OFF_MODE:     next_s.rdata = {31'h00000000, s.priv};
        OFF_FLAGS:    next_s.rdata = {28'h0000000, s.flags};
        OFF_RESULT:   next_s.rdata = s.result;
        OFF_STATUS:   next_s.rdata = {29'h00000000, s.outcome, busy_now};
        OFF_INT_STAT: next_s.rdata = {29'h00000000, s.stat};
        OFF_INT_MASK: next_s.rdata = {29'h00000000, s.mask};
        default:      next_s.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      s       <= '0;
      s.flags <= FLAGS_RST;
    end else begin
      s <= next_s;
    end
  end

  // Zero-wait slave, always OKAY
  assign hreadyout    = 1'b1;
  assign hresp        = 1'b0;
  assign hrdata       = s.rdata;
  assign irq          = |(s.stat & s.mask);
  assign cp.offer     = s.offer;
  assign cp.instr     = s.instr;
  assign cp.core_data = s.core_data;
endmodule
`default_nettype wire

//--- testbench/crt_link_sva.sv
// Assertions on the coprocessor handshake between the processor end and the coprocessor end
`timescale 1ns/10ps
`default_nettype none
module crt_link_sva #(
  parameter int unsigned CP_NUM = 1
) (
  input wire logic        mclk,
  input wire logic        sys_rst,
  input wire logic        offer,
  input wire logic [31:0] instr,
  input wire logic [31:0] core_data,
  input wire logic        absent,
  input wire logic        busy,
  input wire logic [31:0] cp_data
);
  localparam int BUSY_MAX = 8;
  logic is_xfer;
  logic is_undef;
  logic mine;
  // Own decode of the offered word, kept apart from the design's helpers
  assign is_xfer  = (instr[27:24] == 4'hE) && instr[4];
  assign is_undef = (instr[27:25] == 3'h3) && instr[4];
  assign mine     = is_xfer && (instr[11:8] == CP_NUM[3:0]);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  a_ctrl_never_offered: assert property (offer && is_xfer |-> instr[11:8] != 4'hF)
    else $error("control coprocessor number seen on the link");
  a_other_num_absent: assert property (offer && is_xfer && !mine |-> absent)
    else $error("coprocessor answered a foreign number");
  a_own_num_present: assert property (offer && mine |-> !absent)
    else $error("coprocessor ignored its own number");
  a_undef_declined: assert property (offer && is_undef |-> absent && busy)
    else $error("undefined instruction was not declined");
  a_only_xfer_offered: assert property (offer |-> is_xfer || is_undef)
    else $error("data operation reached the link");
  a_busy_bounded: assert property ($rose(offer) && !absent |-> ##[1:BUSY_MAX] !busy)
    else $error("transfer never accepted");
  a_offer_drops: assert property (offer && (absent || !busy) |=> !offer)
    else $error("offer held after the single word moved");
  a_offer_holds: assert property (offer && !absent && busy |=> offer && $stable(instr) && $stable(core_data))
    else $error("offer changed while the coprocessor was busy");
  a_idle_quiet: assert property (!offer |-> !absent && !busy)
    else $error("handshake lines active without an offer");
endmodule
`default_nettype wire

//--- testbench/testbench.sv
// Self-checking bench joining the processor end to the coprocessor end over the handshake
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import crt_pkg::*;
  logic        mclk;
  logic        sys_rst;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic        hready;
  logic        hresp;
  logic [31:0] hrdata;
  logic        irq;
  logic [3:0]  peek_sel;
  logic [31:0] peek_data;
  logic        xfer_dir;
  logic        xfer_pulse;
  logic [31:0] rd;
  int          failures;
  int          samples_checked;
  int          pulses;
  crt_if link ();
  crt_core_end crt_core_end_i (.mclk(mclk), .sys_rst(sys_rst), .cp(link), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .irq(irq));
  crt_copro_end #(.CP_NUM(1), .BUSY_CYCLES(2)) crt_copro_end_i (.mclk(mclk), .sys_rst(sys_rst),
    .cp(link), .peek_sel(peek_sel), .peek_data(peek_data), .xfer_pulse(xfer_pulse), .xfer_dir(xfer_dir));
  crt_link_sva #(.CP_NUM(1)) crt_link_sva_i (.mclk(mclk), .sys_rst(sys_rst), .offer(link.offer),
    .instr(link.instr), .core_data(link.core_data), .absent(link.absent), .busy(link.busy),
    .cp_data(link.cp_data));
  // Register transfer word; opcode, info and secondary register are nonzero since neither end reads them
  function automatic logic [31:0] mk(input logic [3:0] c, input logic l, input logic [3:0] n,
                                     input logic [3:0] r, input logic [3:0] p);
    return {c, 4'hE, 3'h5, l, n, r, p, 3'h2, 1'h1, 4'h7};
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One single AHB-Lite transfer; the address phase is held until hready is sampled high
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge mclk);
    hsel   <= 1'h1;
    haddr  <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge mclk); while (hready !== 1'h1);
    hsel   <= 1'h0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge mclk); while (hready !== 1'h1);
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'h1, a, d);
  endtask
  task automatic rdr(input logic [7:0] a);
    bus(1'h0, a, 32'h0);
  endtask
  // Start one instruction, poll until idle, then compare the outcome field
  task automatic run(input logic [31:0] ins, input logic [1:0] outc);
    int i;
    wr(OFF_INT_STAT, 32'h7);
    wr(OFF_INSTR, ins);
    for (i = 0; i < 40; i++) begin
      rdr(OFF_STATUS);
      if (rd[0] === 1'h0) break;
    end
    check({31'h0, rd[0]}, 32'h0);
    check({30'h0, rd[2:1]}, {30'h0, outc});
  endtask
  // Irq is sampled mid-cycle so the register update of the last write has landed
  task automatic chk_irq(input logic e);
    @(negedge mclk);
    check({31'h0, irq}, {31'h0, e});
  endtask
  // Count accepted transfers; each one must raise exactly one pulse
  always @(posedge mclk) begin
    if (xfer_pulse === 1'h1) begin
      pulses++;
    end
  end
  task automatic report_and_stop;
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    mclk = 1'h0;
    forever #10 mclk = ~mclk;
  end
  // Span covers all tests several times over
  initial begin
    repeat (20000) @(posedge mclk);
    failures++;
    $display("watchdog expired");
    report_and_stop();
  end
  initial begin
    sys_rst = 1'h1; hsel = 1'h0; haddr = 32'h0; htrans = 2'h0; hwrite = 1'h0;
    hsize = 3'h2; hwdata = 32'h0; peek_sel = 4'h0; failures = 0; samples_checked = 0; pulses = 0;
    repeat (4) @(posedge mclk);
    sys_rst <= 1'h0;
    wr(OFF_MODE, 32'h1);
    wr(OFF_PC, 32'hD0001000);
    wr(OFF_OPERAND, 32'h9ABCDEF1);
    wr(OFF_FLAGS, 32'h4);
    run(mk(4'hE, 1'h0, 4'h3, 4'h0, 4'h1), OUT_DONE);
    peek_sel <= 4'h3;
    rdr(OFF_RESULT);
    check(peek_data, 32'h9ABCDEF1);
    check({31'h0, xfer_dir}, 32'h0);
    run(mk(4'hE, 1'h1, 4'h3, 4'h0, 4'h1), OUT_DONE);
    rdr(OFF_RESULT);
    check(rd, 32'h9ABCDEF1);
    check({31'h0, xfer_dir}, 32'h1);
    run(mk(4'hE, 1'h0, 4'h4, 4'hF, 4'h1), OUT_DONE);
    peek_sel <= 4'h4;
    rdr(OFF_PC);
    check(peek_data, 32'hD000100C);
    run(mk(4'hE, 1'h1, 4'h4, 4'hF, 4'h1), OUT_DONE);
    rdr(OFF_FLAGS);
    check(rd, 32'hD);
    rdr(OFF_PC);
    check(rd, 32'hD0001000);
    rdr(OFF_RESULT);
    check(rd, 32'h9ABCDEF1);
    $display("test moves done");
    run(mk(4'h0, 1'h0, 4'h2, 4'h0, 4'h1), OUT_DONE);
    run(mk(4'h1, 1'h0, 4'h2, 4'h0, 4'h1), OUT_SKIP);
    run(mk(4'hF, 1'h0, 4'h2, 4'h0, 4'h1), OUT_SKIP);
    run(mk(4'hE, 1'h0, 4'h3, 4'h0, 4'h2), OUT_TRAP);
    run({4'hE, 4'hE, 24'h123400}, OUT_TRAP);
    run({4'hE, 3'h3, 25'h10}, OUT_TRAP);
    check(pulses, 32'h5);
    $display("test conditions and traps done");
    wr(OFF_OPERAND, 32'h13572468);
    run(mk(4'hE, 1'h0, 4'h1, 4'h0, 4'hF), OUT_DONE);
    run(mk(4'hE, 1'h1, 4'h1, 4'h0, 4'hF), OUT_DONE);
    rdr(OFF_RESULT);
    check(rd, 32'h13572468);
    run(mk(4'hE, 1'h1, 4'h1, 4'hF, 4'hF), OUT_DONE);
    rdr(OFF_FLAGS);
    check(rd, 32'h1);
    rdr(OFF_RESULT);
    check(rd, 32'h13572468);
    run(mk(4'hE, 1'h1, 4'h0, 4'h0, 4'hF), OUT_DONE);
    rdr(OFF_RESULT);
    check(rd, CTRL_ID_RST);
    run(mk(4'hE, 1'h1, 4'h8, 4'h0, 4'hF), OUT_TRAP);
    run(mk(4'hE, 1'h0, 4'hF, 4'h0, 4'hF), OUT_TRAP);
    wr(OFF_MODE, 32'h0);
    run(mk(4'hE, 1'h1, 4'h1, 4'h0, 4'hF), OUT_TRAP);
    $display("test control coprocessor done");
    rdr(OFF_INT_STAT);
    check(rd, 32'h2);
    wr(OFF_INT_MASK, 32'h2);
    chk_irq(1'h1);
    wr(OFF_INT_MASK, 32'h1);
    chk_irq(1'h0);
    wr(OFF_INT_MASK, 32'h2);
    wr(OFF_INT_STAT, 32'h2);
    chk_irq(1'h0);
    rdr(8'h40);
    check(rd, 32'h0);
    check({31'h0, hresp}, 32'h0);
    $display("test interrupts done");
    report_and_stop();
  end
endmodule
`default_nettype wire
